// ---- design/smi_consts.vh ----
// constants for the supply-margin serial slave
`ifndef SMI_CONSTS_VH
`define SMI_CONSTS_VH

`define SMI_SYNC_W 10
`define SMI_SYNC_RST 10'h00F
`define SMI_PIN_SCL 0
`define SMI_PIN_SDA 1
`define SMI_PIN_WP_N 2
`define SMI_PIN_READY 3
`define SMI_PIN_MON1 4
`define SMI_PIN_MON2 5
`define SMI_PIN_REACHED 6

`define SMI_REG_NOM_HI 8'h00
`define SMI_REG_NOM_LO 8'h01
`define SMI_REG_OUTCTL 8'h04
`define SMI_REG_IDENT 8'h05
`define SMI_REG_LOCK 8'h06
`define SMI_REG_MARGIN_CMD 8'h08
`define SMI_REG_HIGH_HI 8'h20
`define SMI_REG_HIGH_LO 8'h21
`define SMI_REG_LOW_HI 8'h30
`define SMI_REG_LOW_LO 8'h31
`define SMI_REG_MARGIN_STAT 8'h40
`define SMI_REG_POLARITY 8'h41
`define SMI_REG_UNLOCK 8'h42
`define SMI_REG_FAULT_STAT 8'h44
`define SMI_REG_CFG_LAST 8'h45
`define SMI_MEM_FIRST 8'h80

`define SMI_OUTCTL_EN_BIT 0
`define SMI_LATCH_SEL_BIT 6
`define SMI_LOCK_BIT 7
`define SMI_READY_POL_BIT 0

`define SMI_OUTCTL_RST 8'h25
`define SMI_IDENT_RST 8'h05
`define SMI_POLARITY_RST 8'h03
`define SMI_UNLOCK_RST 8'h00
`define SMI_UNLOCK_CODE 4'h5

`define SMI_CMD_HIGH 2'h1
`define SMI_CMD_LOW 2'h2

`define SMI_PAGE_BYTES 16
`define SMI_TWR_MS 5
`define SMI_CLK_PERIOD_NS 5
`define SMI_TWR_CYCLES 20'd1000000

`endif

// ---- design/smi_i2c_slave.v ----
// serial slave, register space and margin control of the supply marginer
// Operation
// - live fault bits follow both monitor inputs
// - latched bits capture inputs on selected event
// - ready asserted once supply reaches set point
// - external low on ready latches monitor inputs
// - margin commands only with output control enabled
// - two-bit command picks high, low, nominal
// - ready drops during margin, status set after
// - volatile protection, protected after every reset
// - unlock register nibbles 0101 unlock areas
// - protect pin blocks all nonvolatile writes
// - lock bit blocks configuration writes until the next reset
// - sample on rising, change on falling, msb first
// - eight bits then one acknowledge clock
// - address byte is type, bus address, direction
// - one programmable type identifier for all spaces
// - bus address must match address pins
// - write: address, pointer, up to sixteen bytes
// - stop commits buffered bytes to nonvolatile store
// - dummy write sets pointer, repeated start reads
// - acknowledged reads continue at incremented addresses
// - config at 00 to 45, memory 80 to FF
`timescale 1ns/1ps
`include "smi_consts.vh"

module smi_i2c_slave
#(
    parameter [19:0] NV_WRITE_CYCLES = `SMI_TWR_CYCLES
)
(
    input wire clk,
    input wire reset,
    input wire ce,
    input wire scl,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire write_protect_n,
    input wire ready_in,
    output reg ready_out,
    output reg ready_oe,
    output reg fault_n_out,
    output reg fault_n_oe,
    input wire monitor_input_one,
    input wire monitor_input_two,
    input wire target_reached,
    input wire bus_addr_pin_2,
    input wire bus_addr_pin_1,
    input wire bus_addr_pin_0,
    output reg [15:0] control_target,
    output reg margin_active,
    output reg nv_busy
);

localparam S_IDLE = 3'd0;
localparam S_ADDR = 3'd1;
localparam S_PTR = 3'd2;
localparam S_WR = 3'd3;
localparam S_RD = 3'd4;

wire [`SMI_SYNC_W-1:0] pins;
reg [`SMI_SYNC_W-1:0] pins_d;

smi_sync u_sync
(
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .async_in({bus_addr_pin_2, bus_addr_pin_1, bus_addr_pin_0, target_reached,
               monitor_input_two, monitor_input_one, ready_in, write_protect_n,
               sda_in, scl}),
    .sync_out(pins)
);

reg [7:0] mem [0:255];
reg [7:0] wbuf [0:`SMI_PAGE_BYTES-1];
reg [2:0] state;
reg [7:0] shreg;
reg [7:0] tx;
reg [3:0] bit_cnt;
reg in_ack;
reg rw;
reg rd_nack;
reg [7:0] ptr;
reg [7:0] base;
reg [4:0] wr_cnt;
reg [7:0] unlock;
reg [19:0] busy_cnt;
reg [1:0] live;
reg [1:0] latched;
reg margin_done;
reg [1:0] margin_mode;
reg fault_d;
integer i;
integer j;

wire scl_s = pins[`SMI_PIN_SCL];
wire sda_s = pins[`SMI_PIN_SDA];
wire scl_rise = scl_s & ~pins_d[`SMI_PIN_SCL];
wire scl_fall = ~scl_s & pins_d[`SMI_PIN_SCL];
wire start_det = scl_s & pins_d[`SMI_PIN_SCL] & pins_d[`SMI_PIN_SDA] & ~sda_s;
wire stop_det = scl_s & pins_d[`SMI_PIN_SCL] & ~pins_d[`SMI_PIN_SDA] & sda_s;
wire commit = stop_det & (state == S_WR) & (wr_cnt != 5'd0);
wire ready_fall = pins_d[`SMI_PIN_READY] & ~pins[`SMI_PIN_READY];
wire fault_now = pins[`SMI_PIN_MON1] | pins[`SMI_PIN_MON2];
wire outctl_en = mem[`SMI_REG_OUTCTL][`SMI_OUTCTL_EN_BIT];
wire ready_high = mem[`SMI_REG_POLARITY][`SMI_READY_POL_BIT];
wire ready_level = ~margin_active & pins[`SMI_PIN_REACHED];
wire [2:0] my_bus_addr = pins[9:7];

// read value of one address, with status and write-only registers overlaid
function [7:0] read_value;
    input [7:0] addr;
    begin
        case (addr)
            `SMI_REG_UNLOCK: read_value = 8'h00;
            `SMI_REG_MARGIN_STAT: read_value = {5'h00, margin_mode, margin_done};
            `SMI_REG_FAULT_STAT: read_value = {4'h0, latched, live};
            default: read_value = mem[addr];
        endcase
    end
endfunction
wire [7:0] rd_byte = read_value(ptr);
// address of the n-th byte of a page write, wrapping inside the page
function [7:0] page_addr;
    input [7:0] b;
    input [3:0] n;
    begin
        page_addr = {b[7:4], b[3:0] + n};
    end
endfunction

// true when a stored byte at this address may be changed
function write_allowed;
    input [7:0] addr;
    input pin_n;
    input [7:0] code;
    input lock;
    begin
        if (addr == `SMI_REG_UNLOCK || addr == `SMI_REG_MARGIN_CMD)
            write_allowed = 1'b1;
        else if (addr >= `SMI_MEM_FIRST)
            write_allowed = pin_n & (code[7:4] == `SMI_UNLOCK_CODE);
        else if (addr <= `SMI_REG_CFG_LAST && addr != `SMI_REG_MARGIN_STAT
                 && addr != `SMI_REG_FAULT_STAT)
            write_allowed = pin_n & (code[3:0] == `SMI_UNLOCK_CODE) & ~lock;
        else
            write_allowed = 1'b0;
    end
endfunction

// serial protocol engine
always @(posedge clk)
begin
    if (reset)
    begin
        pins_d <= `SMI_SYNC_RST;
        state <= S_IDLE;
        shreg <= 8'h00;
        tx <= 8'h00;
        bit_cnt <= 4'h0;
        in_ack <= 1'b0;
        rw <= 1'b0;
        rd_nack <= 1'b0;
        ptr <= 8'h00;
        base <= 8'h00;
        wr_cnt <= 5'h00;
        sda_out <= 1'b0;
        sda_oe <= 1'b0;
        for (i = 0; i < `SMI_PAGE_BYTES; i = i + 1)
            wbuf[i] <= 8'h00;
    end
    else if (ce)
    begin
        pins_d <= pins;
        if (start_det)
        begin
            state <= S_ADDR;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            sda_oe <= 1'b0;
            wr_cnt <= 5'h00;
        end
        else if (stop_det)
        begin
            state <= S_IDLE;
            sda_oe <= 1'b0;
            wr_cnt <= 5'h00;
        end
        else if (state != S_IDLE && scl_rise)
        begin
            if (bit_cnt < 4'd8)
            begin
                shreg <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'd1;
            end
            else
                rd_nack <= sda_s;
        end
        else if (state != S_IDLE && scl_fall)
        begin
            if (bit_cnt == 4'd8 && !in_ack)
            begin
                in_ack <= 1'b1;
                case (state)
                    S_ADDR:
                    begin
                        rw <= shreg[0];
                        if (shreg[7:4] == mem[`SMI_REG_IDENT][3:0]
                            && shreg[3:1] == my_bus_addr && !nv_busy)
                            sda_oe <= 1'b1;
                        else
                            state <= S_IDLE;
                    end
                    S_PTR:
                    begin
                        ptr <= shreg;
                        base <= shreg;
                        sda_oe <= 1'b1;
                    end
                    S_WR:
                    begin
                        if (wr_cnt < `SMI_PAGE_BYTES)
                        begin
                            wbuf[wr_cnt[3:0]] <= shreg;
                            wr_cnt <= wr_cnt + 5'd1;
                        end
                        sda_oe <= 1'b1;
                    end
                    default:
                        sda_oe <= 1'b0;
                endcase
            end
            else if (in_ack)
            begin
                in_ack <= 1'b0;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
                case (state)
                    S_ADDR:
                    begin
                        if (rw)
                        begin
                            state <= S_RD;
                            sda_oe <= ~rd_byte[7];
                            tx <= {rd_byte[6:0], 1'b1};
                            ptr <= ptr + 8'd1;
                        end
                        else
                            state <= S_PTR;
                    end
                    S_PTR:
                        state <= S_WR;
                    S_RD:
                    begin
                        if (rd_nack)
                            state <= S_IDLE;
                        else
                        begin
                            sda_oe <= ~rd_byte[7];
                            tx <= {rd_byte[6:0], 1'b1};
                            ptr <= ptr + 8'd1;
                        end
                    end
                    default:
                        state <= state;
                endcase
            end
            else if (state == S_RD && bit_cnt != 4'd0)
            begin
                sda_oe <= ~tx[7];
                tx <= {tx[6:0], 1'b1};
            end
        end
    end
end

// register store, protection, margin control and monitor status
always @(posedge clk)
begin : core
    if (reset)
    begin
        for (j = 0; j < 256; j = j + 1)
            mem[j] <= 8'h00;
        mem[`SMI_REG_OUTCTL] <= `SMI_OUTCTL_RST;
        mem[`SMI_REG_IDENT] <= `SMI_IDENT_RST;
        mem[`SMI_REG_POLARITY] <= `SMI_POLARITY_RST;
        unlock <= `SMI_UNLOCK_RST;
        nv_busy <= 1'b0;
        busy_cnt <= 20'h00000;
        live <= 2'h0;
        latched <= 2'h0;
        fault_d <= 1'b0;
        margin_done <= 1'b0;
        margin_mode <= 2'h0;
        margin_active <= 1'b0;
        control_target <= 16'h0000;
        ready_out <= 1'b0;
        ready_oe <= 1'b0;
        fault_n_out <= 1'b0;
        fault_n_oe <= 1'b0;
    end
    else if (ce)
    begin
        live <= {pins[`SMI_PIN_MON2], pins[`SMI_PIN_MON1]};
        fault_d <= fault_now;
        if (mem[`SMI_REG_OUTCTL][`SMI_LATCH_SEL_BIT] ? ready_fall : (fault_now & ~fault_d))
            latched <= {pins[`SMI_PIN_MON2], pins[`SMI_PIN_MON1]};
        fault_n_oe <= fault_now;
        // open drain: pulled low when not ready for active high, when ready for active low
        ready_oe <= ready_high ? ~ready_level : ready_level;
        if (margin_active && pins[`SMI_PIN_REACHED])
        begin
            margin_active <= 1'b0;
            margin_done <= 1'b1;
        end
        if (nv_busy)
        begin
            if (busy_cnt >= NV_WRITE_CYCLES - 20'd1)
                nv_busy <= 1'b0;
            busy_cnt <= busy_cnt + 20'd1;
        end
        if (commit)
        begin
            if (base != `SMI_REG_UNLOCK && base != `SMI_REG_MARGIN_CMD)
            begin
                nv_busy <= 1'b1;
                busy_cnt <= 20'h00000;
            end
            for (j = 0; j < `SMI_PAGE_BYTES; j = j + 1)
            begin
                if (j < wr_cnt
                    && write_allowed(page_addr(base, j[3:0]), pins[`SMI_PIN_WP_N], unlock,
                                     mem[`SMI_REG_LOCK][`SMI_LOCK_BIT]))
                begin
                    if (page_addr(base, j[3:0]) == `SMI_REG_UNLOCK)
                        unlock <= wbuf[j];
                    else
                        mem[page_addr(base, j[3:0])] <= wbuf[j];
                    if (page_addr(base, j[3:0]) == `SMI_REG_MARGIN_CMD && outctl_en)
                    begin
                        margin_active <= 1'b1;
                        margin_done <= 1'b0;
                        margin_mode <= wbuf[j][1:0];
                        case (wbuf[j][1:0])
                            `SMI_CMD_HIGH:
                                control_target <= {mem[`SMI_REG_HIGH_HI],
                                                   mem[`SMI_REG_HIGH_LO]};
                            `SMI_CMD_LOW:
                                control_target <= {mem[`SMI_REG_LOW_HI],
                                                   mem[`SMI_REG_LOW_LO]};
                            default:
                                control_target <= {mem[`SMI_REG_NOM_HI],
                                                   mem[`SMI_REG_NOM_LO]};
                        endcase
                    end
                end
            end
        end
    end
end

endmodule // smi_i2c_slave

// ---- design/smi_sync.v ----
// two-flop synchroniser for all pin inputs
`timescale 1ns/1ps
`include "smi_consts.vh"

module smi_sync
(
    input wire clk,
    input wire reset,
    input wire ce,
    input wire [`SMI_SYNC_W-1:0] async_in,
    output reg [`SMI_SYNC_W-1:0] sync_out
);

reg [`SMI_SYNC_W-1:0] stage_one;

always @(posedge clk)
begin
    if (reset)
    begin
        stage_one <= `SMI_SYNC_RST;
        sync_out <= `SMI_SYNC_RST;
    end
    else if (ce)
    begin
        stage_one <= async_in;
        sync_out <= stage_one;
    end
end

endmodule // smi_sync

// ---- dv/smi_host_model.sv ----
// bus host model driving the serial clock and pulling data low
`timescale 1ns/1ps
module smi_host_model
(
    input wire clk,
    input wire sda,
    output reg scl,
    output reg sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task w(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data moves only in the low phase, sampled late in the high phase
    task xbit(input logic b, output logic s);
        w(6);
        sda_low <= !b;
        w(7);
        scl <= 1'b1;
        w(11);
        s = sda;
        w(1);
        scl <= 1'b0;
    endtask
    // data edge while the clock is high frames a transfer
    task cond(input logic a, input logic b);
        w(6);
        sda_low <= a;
        w(7);
        scl <= 1'b1;
        w(12);
        sda_low <= b;
        w(12);
    endtask
    task start;
        cond(1'b0, 1'b1);
        scl <= 1'b0;
    endtask
    task stop;
        cond(1'b1, 1'b0);
    endtask
    task wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            xbit(d[i], s);
        xbit(1'b1, s);
        ack = !s;
    endtask
    task rbyte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            xbit(1'b1, s);
            d[i] = s;
        end
        xbit(!more, s);
    endtask
endmodule // smi_host_model

// ---- dv/smi_i2c_slave_properties.sv ----
// port assertions for the supply-margin serial slave
`timescale 1ns/1ps
module smi_slave_checker
#(
    parameter [19:0] NV_WRITE_CYCLES = 20'd50
)
(
    input wire clk,
    input wire reset,
    input wire scl,
    input wire sda_oe,
    input wire ready_oe,
    input wire fault_n_oe,
    input wire monitor_input_one,
    input wire monitor_input_two,
    input wire target_reached,
    input wire margin_active,
    input wire nv_busy
);
    logic [19:0] busy_len;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    always @(posedge clk)
    begin
        if (reset || !nv_busy)
            busy_len <= 20'h00000;
        else
            busy_len <= busy_len + 20'h00001;
    end
    sequence s_fault; (monitor_input_one || monitor_input_two) [*5]; endsequence
    sequence s_clear; (!monitor_input_one && !monitor_input_two) [*5]; endsequence
    sequence s_arrived; (margin_active && target_reached) [*5]; endsequence
    sequence s_settled; (target_reached && !margin_active) [*5]; endsequence
    property p_fault_on; s_fault |-> fault_n_oe; endproperty
    property p_fault_off; s_clear |-> !fault_n_oe; endproperty
    property p_ready_drop; $rose(margin_active) |-> ##[0:2] ready_oe; endproperty
    property p_ready_set; s_settled |-> !ready_oe; endproperty
    property p_margin_end; s_arrived |=> !margin_active; endproperty
    property p_busy_quiet; nv_busy |-> !sda_oe; endproperty
    property p_busy_len; $fell(nv_busy) |-> busy_len == NV_WRITE_CYCLES; endproperty
    property p_sda_change; $changed(sda_oe) |-> !scl; endproperty
    a_fault_on: assert property (p_fault_on) else $error("fault pin idle");
    a_fault_off: assert property (p_fault_off) else $error("fault pin stuck");
    a_ready_drop: assert property (p_ready_drop) else $error("ready kept");
    a_ready_set: assert property (p_ready_set) else $error("ready missing");
    a_margin_end: assert property (p_margin_end) else $error("margin hangs");
    a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
    a_busy_len: assert property (p_busy_len) else $error("busy length");
    a_sda_change: assert property (p_sda_change) else $error("data moved high");
endmodule // smi_slave_checker
bind smi_i2c_slave smi_slave_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_checker (
    .clk(clk), .reset(reset), .scl(scl), .sda_oe(sda_oe), .ready_oe(ready_oe),
    .fault_n_oe(fault_n_oe), .monitor_input_one(monitor_input_one),
    .monitor_input_two(monitor_input_two), .target_reached(target_reached),
    .margin_active(margin_active), .nv_busy(nv_busy));

// ---- dv/tb_smi_i2c_slave.sv ----
// self-checking bench for the supply-margin serial slave
`timescale 1ns/1ps
module tb_smi_i2c_slave;
    logic clk;
    logic reset = 1'b1;
    logic wp_n = 1'b1;
    logic mon1 = 1'b0;
    logic mon2 = 1'b0;
    logic reached = 1'b0;
    logic rdy_low = 1'b0;
    wire scl;
    wire sda_low;
    wire sda_oe;
    wire ready_oe;
    wire fault_n_oe;
    wire margin_active;
    wire nv_busy;
    wire [15:0] control_target;
    wire sda = !(sda_oe || sda_low);
    wire ready_pin = !(ready_oe || rdy_low);
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    smi_host_model h (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    smi_i2c_slave #(.NV_WRITE_CYCLES(20'd400)) dut (.clk(clk), .reset(reset), .ce(1'b1),
        .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .write_protect_n(wp_n),
        .ready_in(ready_pin), .ready_out(), .ready_oe(ready_oe), .fault_n_out(),
        .fault_n_oe(fault_n_oe), .monitor_input_one(mon1), .monitor_input_two(mon2),
        .target_reached(reached), .bus_addr_pin_2(1'b1), .bus_addr_pin_1(1'b0),
        .bus_addr_pin_0(1'b1), .control_target(control_target),
        .margin_active(margin_active), .nv_busy(nv_busy));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            bad_count++;
            finish_test;
        end
    end
    task finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task idle;
        for (int i = 0; i < 1000 && nv_busy !== 1'b0; i++)
            step(1);
    endtask
    task probe(input logic [7:0] ab, input logic exp);
        logic ak;
        h.start;
        h.wbyte(ab, ak);
        h.stop;
        chk(ak, exp);
    endtask
    task wr(input logic [7:0] p, input logic [7:0] d, input int n);
        logic ak;
        idle;
        h.start;
        h.wbyte(8'h5A, ak);
        h.wbyte(p, ak);
        for (int i = 0; i < n; i++)
            h.wbyte(d + 8'(i), ak);
        h.stop;
    endtask
    task rd(input logic [7:0] p, input logic [7:0] e, input int n);
        logic ak;
        logic [7:0] d;
        idle;
        h.start;
        h.wbyte(8'h5A, ak);
        h.wbyte(p, ak);
        h.start;
        h.wbyte(8'h5B, ak);
        for (int i = 0; i < n; i++)
        begin
            h.rbyte(i < n - 1, d);
            chk(d, e + 8'(i));
        end
        h.stop;
    endtask
    task t_reset;
        chk(sda_oe, 1'b0);
        chk(nv_busy, 1'b0);
        chk(control_target, 16'h0000);
        chk(ready_oe, 1'b1);
    endtask
    task t_addr;
        probe(8'h6A, 1'b0);
        probe(8'h58, 1'b0);
        probe(8'h5A, 1'b1);
    endtask
    task t_protect;
        wr(8'h80, 8'hA5, 1);
        rd(8'h80, 8'h00, 1);
        wr(8'h42, 8'h55, 1);
        rd(8'h42, 8'h00, 1);
        wr(8'h8E, 8'h11, 3);
        probe(8'h5A, 1'b0);
        rd(8'h8E, 8'h11, 2);
        rd(8'h80, 8'h13, 1);
        wp_n <= 1'b0;
        wr(8'h90, 8'h77, 1);
        wp_n <= 1'b1;
        rd(8'h90, 8'h00, 1);
        wr(8'h42, 8'h95, 1);
        wr(8'h90, 8'h77, 1);
        rd(8'h90, 8'h00, 1);
        wr(8'h20, 8'h12, 2);
        wr(8'h30, 8'h34, 2);
        rd(8'h20, 8'h12, 2);
        wr(8'h50, 8'h99, 1);
        rd(8'h50, 8'h00, 1);
    endtask
    task t_fault;
        mon1 <= 1'b1;
        step(10);
        chk(fault_n_oe, 1'b1);
        rd(8'h44, 8'h05, 1);
        mon1 <= 1'b0;
        step(10);
        chk(fault_n_oe, 1'b0);
        rd(8'h44, 8'h04, 1);
    endtask
    task t_margin;
        logic [1:0] cmd [3] = '{2'h1, 2'h2, 2'h0};
        logic [15:0] tgt [3] = '{16'h1213, 16'h3435, 16'h0000};
        for (int i = 0; i < 3; i++)
        begin
            reached <= 1'b0;
            wr(8'h08, {6'h00, cmd[i]}, 1);
            step(10);
            chk(margin_active, 1'b1);
            chk(ready_oe, 1'b1);
            chk(control_target, tgt[i]);
            reached <= 1'b1;
            step(10);
            chk(margin_active, 1'b0);
            chk(ready_oe, 1'b0);
            rd(8'h40, {5'h00, cmd[i], 1'b1}, 1);
        end
        reached <= 1'b0;
        wr(8'h04, 8'h64, 1);
        wr(8'h08, 8'h01, 1);
        step(10);
        chk(margin_active, 1'b0);
        chk(control_target, 16'h0000);
    endtask
    task t_latch;
        reached <= 1'b1;
        mon2 <= 1'b1;
        rd(8'h44, 8'h06, 1);
        rdy_low <= 1'b1;
        step(10);
        rdy_low <= 1'b0;
        rd(8'h44, 8'h0A, 1);
    endtask
    task t_lock;
        wr(8'h06, 8'h80, 1);
        wr(8'h00, 8'h12, 1);
        rd(8'h00, 8'h00, 1);
    endtask
    initial
    begin
        step(3);
        reset <= 1'b0;
        step(4);
        t_reset;
        t_addr;
        t_protect;
        t_fault;
        t_margin;
        t_latch;
        t_lock;
        finish_test;
    end
endmodule // tb_smi_i2c_slave
